// ### common/acls_consts.vh
// register offsets, field positions and reset values of the audio setup / link status bank
`ifndef ACLS_CONSTS_VH
`define ACLS_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define ACLS_AUDIO_SETUP_ADDR 8'h55
`define ACLS_LINK_STATUS_ADDR 8'h5A
`define ACLS_BRIDGE_CTL_ADDR 8'h60

// ****************************************
// reset values and write masks
// ****************************************
`define ACLS_AUDIO_SETUP_RESET 8'h0C
`define ACLS_LINK_STATUS_RESET 8'h00
`define ACLS_BRIDGE_CTL_RESET 8'h00
`define ACLS_AUDIO_SETUP_MASK 8'hCF
`define ACLS_BRIDGE_CTL_MASK 8'h02

// ****************************************
// audio setup fields
// ****************************************
`define ACLS_AS_TDM_CONV 7
`define ACLS_AS_RX_AUDIO_OUT 6
`define ACLS_AS_FLUSH_TYPE 3
`define ACLS_AS_FLUSH_AUDIO_INFO 2
`define ACLS_AS_FLUSH_VIDEO_INFO 1
`define ACLS_AS_FLUSH_CLOCK_REGEN 0

// ****************************************
// link status fields
// ****************************************
`define ACLS_LS_LINK_READY 7
`define ACLS_LS_TX_ACTIVE 6
`define ACLS_LS_PORT_HI 5
`define ACLS_LS_PORT_LO 4
`define ACLS_LS_SYMBOLS 3
`define ACLS_LS_PLL_LOCK 2
`define ACLS_LS_NO_CLOCK 1
`define ACLS_LS_CLK_STEADY 0

// ****************************************
// bridge control fields and encodings
// ****************************************
`define ACLS_BC_AUDIO_SRC 1
`define ACLS_SRC_RX_ONLY 1'h0
`define ACLS_PORT_DUAL 2'h0
`define ACLS_PORT_SINGLE0 2'h1
`define ACLS_PORT_SINGLE1 2'h2
`define ACLS_PORT_REPLICATE 2'h3

`endif

// ### src/acls_sync.v
// three-stage synchroniser for one status level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none

module acls_sync (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // level in and out
    input wire async_in,
    output reg sync_out
);

reg stage1;
reg stage2;
reg stage3;

// stage1 only feeds stage2; the output moves once stages 2 and 3 agree
always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        stage1 <= 1'h0;
        stage2 <= 1'h0;
        stage3 <= 1'h0;
        sync_out <= 1'h0;
    end else begin
        stage1 <= async_in;
        stage2 <= stage1;
        stage3 <= stage2;
        if (stage2 == stage3) begin
            sync_out <= stage3;
        end
    end
end

endmodule
`default_nettype wire

// ### src/acls_bank.v
// audio setup and link status register bank with audio fifo flush control
// Overview of operation
// - bit 7 of audio setup enables tdm converter; its clock feeds downstream audio
// - bit 6 drives received audio to serial pins, only when source is received-only
// - bit 3 flushes received-audio fifo on audio type change
// - bit 2 flushes received-audio fifo on audio infoframe checksum change
// - bit 1 flushes received-audio fifo on video infoframe checksum change
// - bit 0 flushes received-audio fifo on clock regen n or cts change
// - link status bit 7 shows downstream link ready
// - bit 6 shows transmitter active, only after valid input and mode entered
// - bits 5:4 show port mode while transmit status is one
// - bit 3 shows valid symbols recovered from input link
// - bit 2 shows input pll locked
// - bit 1 shows no input clock above low-frequency limit
// - bit 0 shows input clock frequency stable
// - audio source zero selects received audio, one selects local serial pins
`timescale 1ns/100ps
`default_nettype none
`include "acls_consts.vh"

module acls_bank (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // raw link status levels, from other clock domains
    input wire link_ready_in,
    input wire tx_locked_in,
    input wire [1:0] port_mode_in,
    input wire symbols_valid_in,
    input wire pll_lock_in,
    input wire no_clock_in,
    input wire clock_steady_in,
    // audio change events, same clock, one-cycle pulses
    input wire audio_type_changed,
    input wire audio_info_changed,
    input wire video_info_changed,
    input wire clock_regen_changed,
    // audio control outputs
    output reg tdm_conv_enable,
    output reg audio_clk_from_tdm,
    output reg rx_audio_to_pins,
    output reg local_audio_select,
    output reg audio_fifo_flush
);

// ****************************************
// synchronise status inputs
// ****************************************
wire [7:0] raw_status;
wire [7:0] sync_status;

assign raw_status = {link_ready_in, tx_locked_in, port_mode_in, symbols_valid_in,
                     pll_lock_in, no_clock_in, clock_steady_in};

genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
        acls_sync u_sync (
            .ref_clk(ref_clk),
            .rst(rst),
            .async_in(raw_status[gi]),
            .sync_out(sync_status[gi])
        );
    end
endgenerate

// ****************************************
// status coherence filter
// ****************************************
// each bit has its own synchroniser, so the two port mode bits may land a cycle
// apart; a word is taken only once it has held for two samples, which costs
// two cycles of status latency but never shows a half-moved mode code
reg [7:0] status_prev;
reg [7:0] status_held;

always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        status_prev <= `ACLS_LINK_STATUS_RESET;
        status_held <= `ACLS_LINK_STATUS_RESET;
    end else begin
        status_prev <= sync_status;
        if (sync_status == status_prev) begin
            status_held <= sync_status;
        end
    end
end

// ****************************************
// status fields
// ****************************************
wire downstream_link_ready;
wire tx_locked;
wire [1:0] serial_port_mode;
wire input_symbols_recovered;
wire input_pll_locked;
wire no_input_clock;
wire input_clock_steady;
wire serial_tx_active;

// raw_status packs the levels in register order, so field positions index it directly
assign downstream_link_ready = status_held[`ACLS_LS_LINK_READY];
assign tx_locked = status_held[`ACLS_LS_TX_ACTIVE];
assign serial_port_mode = status_held[`ACLS_LS_PORT_HI:`ACLS_LS_PORT_LO];
assign input_symbols_recovered = status_held[`ACLS_LS_SYMBOLS];
assign input_pll_locked = status_held[`ACLS_LS_PLL_LOCK];
assign no_input_clock = status_held[`ACLS_LS_NO_CLOCK];
assign input_clock_steady = status_held[`ACLS_LS_CLK_STEADY];
// a locked transmitter counts only once valid input is being recovered
assign serial_tx_active = tx_locked & input_symbols_recovered;

// ****************************************
// address decode
// ****************************************
function [2:0] decode;
    input [7:0] addr;
    begin
        if (addr == `ACLS_AUDIO_SETUP_ADDR) begin
            decode = 3'h1;
        end else if (addr == `ACLS_LINK_STATUS_ADDR) begin
            decode = 3'h2;
        end else if (addr == `ACLS_BRIDGE_CTL_ADDR) begin
            decode = 3'h4;
        end else begin
            decode = 3'h0;
        end
    end
endfunction

wire [2:0] wr_sel;
wire [2:0] rd_sel;
assign wr_sel = reg_wr ? decode(reg_addr) : 3'h0;
assign rd_sel = reg_rd ? decode(reg_addr) : 3'h0;

// named strobes; the status register has no write strobe, so a write there is dropped
wire wr_audio_setup;
wire wr_bridge_ctl;
wire rd_audio_setup;
wire rd_link_status;
wire rd_bridge_ctl;

assign wr_audio_setup = wr_sel[0];
assign wr_bridge_ctl = wr_sel[2];
assign rd_audio_setup = rd_sel[0];
assign rd_link_status = rd_sel[1];
assign rd_bridge_ctl = rd_sel[2];

// ****************************************
// writable registers
// ****************************************
reg [7:0] audio_setup;
reg [7:0] bridge_ctl;
reg [7:0] next_audio_setup;
reg [7:0] next_bridge_ctl;

// reserved bits are masked on the way in, so they can never read back as one
always @* begin
    next_audio_setup = audio_setup;
    if (wr_audio_setup) begin
        next_audio_setup = reg_wdata & `ACLS_AUDIO_SETUP_MASK;
    end
end

// bridge_ctl stands in for the bridge configuration kept elsewhere; only the source bit is held
always @* begin
    next_bridge_ctl = bridge_ctl;
    if (wr_bridge_ctl) begin
        next_bridge_ctl = reg_wdata & `ACLS_BRIDGE_CTL_MASK;
    end
end

always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        audio_setup <= `ACLS_AUDIO_SETUP_RESET;
        bridge_ctl <= `ACLS_BRIDGE_CTL_RESET;
    end else begin
        audio_setup <= next_audio_setup;
        bridge_ctl <= next_bridge_ctl;
    end
end

// ****************************************
// audio setup fields
// ****************************************
wire tdm_conv_on;
wire rx_audio_out_on;
wire fifo_flush_on_type_change;
wire fifo_flush_on_audio_info_change;
wire fifo_flush_on_video_info_change;
wire fifo_flush_on_clock_regen_change;

assign tdm_conv_on = audio_setup[`ACLS_AS_TDM_CONV];
assign rx_audio_out_on = audio_setup[`ACLS_AS_RX_AUDIO_OUT];
assign fifo_flush_on_type_change = audio_setup[`ACLS_AS_FLUSH_TYPE];
assign fifo_flush_on_audio_info_change = audio_setup[`ACLS_AS_FLUSH_AUDIO_INFO];
assign fifo_flush_on_video_info_change = audio_setup[`ACLS_AS_FLUSH_VIDEO_INFO];
assign fifo_flush_on_clock_regen_change = audio_setup[`ACLS_AS_FLUSH_CLOCK_REGEN];

// ****************************************
// link status assembly
// ****************************************
reg [7:0] link_status;

// port mode shows only while the transmitter reports active; otherwise it reads
// as zero, so software never mistakes a stale mode for a live one
always @* begin
    link_status = `ACLS_LINK_STATUS_RESET;
    link_status[`ACLS_LS_LINK_READY] = downstream_link_ready;
    link_status[`ACLS_LS_TX_ACTIVE] = serial_tx_active;
    if (serial_tx_active) begin
        link_status[`ACLS_LS_PORT_HI:`ACLS_LS_PORT_LO] = serial_port_mode;
    end
    link_status[`ACLS_LS_SYMBOLS] = input_symbols_recovered;
    link_status[`ACLS_LS_PLL_LOCK] = input_pll_locked;
    link_status[`ACLS_LS_NO_CLOCK] = no_input_clock;
    link_status[`ACLS_LS_CLK_STEADY] = input_clock_steady;
end

// ****************************************
// read port
// ****************************************
reg [7:0] next_rdata;

// status is read live; nothing latches or clears on a read
always @* begin
    if (rd_audio_setup) begin
        next_rdata = audio_setup;
    end else if (rd_link_status) begin
        next_rdata = link_status;
    end else if (rd_bridge_ctl) begin
        next_rdata = bridge_ctl;
    end else begin
        next_rdata = 8'h00;
    end
end

// read data valid only in the cycle after the strobe
always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        reg_rdata <= 8'h00;
    end else begin
        reg_rdata <= next_rdata;
    end
end

// ****************************************
// audio control
// ****************************************
wire src_local;
wire src_received;
wire next_flush;
wire [3:0] flush_enable;
wire [3:0] change_event;
wire [3:0] flush_request;

assign src_local = bridge_ctl[`ACLS_BC_AUDIO_SRC];
// the source field is one bit here; received-only is its zero code
assign src_received = (src_local == `ACLS_SRC_RX_ONLY);

// audio setup bits 3 down to 0 pair with the four change pulses in the same order
assign flush_enable[3] = fifo_flush_on_type_change;
assign flush_enable[2] = fifo_flush_on_audio_info_change;
assign flush_enable[1] = fifo_flush_on_video_info_change;
assign flush_enable[0] = fifo_flush_on_clock_regen_change;
assign change_event[3] = audio_type_changed;
assign change_event[2] = audio_info_changed;
assign change_event[1] = video_info_changed;
assign change_event[0] = clock_regen_changed;

genvar fi;
generate
    for (fi = 0; fi < 4; fi = fi + 1) begin : g_flush
        assign flush_request[fi] = flush_enable[fi] & change_event[fi];
    end
endgenerate

// pulses in one cycle merge into a single flush; the fifo needs only one
assign next_flush = |flush_request;

always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        tdm_conv_enable <= 1'h0;
        audio_clk_from_tdm <= 1'h0;
        rx_audio_to_pins <= 1'h0;
        local_audio_select <= 1'h0;
        audio_fifo_flush <= 1'h0;
    end else begin
        tdm_conv_enable <= tdm_conv_on;
        audio_clk_from_tdm <= tdm_conv_on;
        rx_audio_to_pins <= rx_audio_out_on & src_received;
        local_audio_select <= src_local;
        audio_fifo_flush <= next_flush;
    end
end

endmodule
`default_nettype wire

// ### dv/acls_bank_asserts.sv
// port checker for the audio setup and link status bank
`timescale 1ns/100ps
`default_nettype none
`include "acls_consts.vh"
module acls_bank_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // audio events and controls
    input wire logic audio_type_changed,
    input wire logic audio_info_changed,
    input wire logic video_info_changed,
    input wire logic clock_regen_changed,
    input wire logic tdm_conv_enable,
    input wire logic audio_clk_from_tdm,
    input wire logic rx_audio_to_pins,
    input wire logic local_audio_select,
    input wire logic audio_fifo_flush
);
    wire any_ev = audio_type_changed | audio_info_changed | video_info_changed | clock_regen_changed;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_tdm_pair: assert property (tdm_conv_enable == audio_clk_from_tdm)
        else $error("tdm outputs differ");
    a_tdm_write: assert property (reg_wr && reg_addr == `ACLS_AUDIO_SETUP_ADDR
        |-> ##2 tdm_conv_enable == $past(reg_wdata[7], 2)) else $error("tdm enable not written");
    a_src_excl: assert property (rx_audio_to_pins |-> !local_audio_select)
        else $error("pins driven with local source");
    a_flush_cause: assert property (audio_fifo_flush |-> $past(any_ev))
        else $error("flush without event");
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read");
    a_setup_resv: assert property ($past(reg_rd) && $past(reg_addr) == `ACLS_AUDIO_SETUP_ADDR
        |-> reg_rdata[5:4] == 2'h0) else $error("reserved bits set");
    a_port_gate: assert property ($past(reg_rd) && $past(reg_addr) == `ACLS_LINK_STATUS_ADDR
        && !reg_rdata[6] |-> reg_rdata[5:4] == 2'h0) else $error("port mode without tx");
    a_tx_valid: assert property ($past(reg_rd) && $past(reg_addr) == `ACLS_LINK_STATUS_ADDR
        && reg_rdata[6] |-> reg_rdata[3]) else $error("tx active without valid input");
    a_unmapped: assert property ($past(reg_rd) && $past(reg_addr) == 8'h33
        |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ### dv/test_audio_cfg_and_link_status.sv
// self-checking bench of the audio setup and link status bank
`timescale 1ns/100ps
`default_nettype none
`include "acls_consts.vh"
module test_audio_cfg_and_link_status;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] st = 8'h00;
    logic [3:0] ev = 4'h0;
    wire [7:0] reg_rdata;
    wire tdm, clk_tdm, pins, loc, flush;
    int error_cnt = 0;
    int compares = 0;
    // status input patterns and what the register must show
    logic [7:0] st_in [6] = '{8'hEF, 8'hF5, 8'h1A, 8'hDF, 8'hFF, 8'hCF};
    logic [7:0] st_exp [6] = '{8'hEF, 8'h85, 8'h0A, 8'hDF, 8'hFF, 8'hCF};
    always #5 ref_clk = ~ref_clk;
    acls_bank u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_ready_in(st[7]),
        .tx_locked_in(st[6]), .port_mode_in(st[5:4]), .symbols_valid_in(st[3]), .pll_lock_in(st[2]),
        .no_clock_in(st[1]), .clock_steady_in(st[0]), .audio_type_changed(ev[3]),
        .audio_info_changed(ev[2]), .video_info_changed(ev[1]), .clock_regen_changed(ev[0]),
        .tdm_conv_enable(tdm), .audio_clk_from_tdm(clk_tdm), .rx_audio_to_pins(pins),
        .local_audio_select(loc), .audio_fifo_flush(flush));
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk); reg_wr <= 1'h1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk); reg_wr <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk); reg_rd <= 1'h1; reg_addr <= a;
        @(posedge ref_clk); reg_rd <= 1'h0;
        #1 chk("read data", e, reg_rdata);
    endtask
    task t_regs;
        rd(`ACLS_AUDIO_SETUP_ADDR, 8'h0C);
        rd(`ACLS_LINK_STATUS_ADDR, 8'h00);
        wr(`ACLS_AUDIO_SETUP_ADDR, 8'hFF);
        @(posedge ref_clk); #1
        chk("audio outputs", 8'h0E, {4'h0, tdm, clk_tdm, pins, loc});
        rd(`ACLS_AUDIO_SETUP_ADDR, 8'hCF);
        wr(`ACLS_BRIDGE_CTL_ADDR, 8'h02);
        @(posedge ref_clk); #1
        chk("audio outputs", 8'h0D, {4'h0, tdm, clk_tdm, pins, loc});
        wr(`ACLS_LINK_STATUS_ADDR, 8'hFF);
        rd(`ACLS_LINK_STATUS_ADDR, 8'h00);
        rd(8'h33, 8'h00);
        wr(`ACLS_BRIDGE_CTL_ADDR, 8'h00);
    endtask
    task t_flush;
        for (int i = 0; i < 4; i++) begin
            wr(`ACLS_AUDIO_SETUP_ADDR, 8'h01 << i);
            @(posedge ref_clk); #1
            chk("audio outputs", 8'h00, {4'h0, tdm, clk_tdm, pins, loc});
            for (int j = 0; j < 4; j++) begin
                @(posedge ref_clk); ev <= 4'h1 << j;
                @(posedge ref_clk); ev <= 4'h0;
                #1 chk("fifo flush", {7'h0, i == j}, {7'h0, flush});
            end
        end
    endtask
    task t_status;
        for (int k = 0; k < 6; k++) begin
            @(posedge ref_clk); st <= st_in[k];
            repeat (8) @(posedge ref_clk);
            rd(`ACLS_LINK_STATUS_ADDR, st_exp[k]);
        end
    endtask
    task end_sim;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'h0;
        t_regs;
        t_flush;
        t_status;
        end_sim;
    end
endmodule
bind acls_bank acls_bank_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .audio_type_changed(audio_type_changed), .audio_info_changed(audio_info_changed),
    .video_info_changed(video_info_changed), .clock_regen_changed(clock_regen_changed),
    .tdm_conv_enable(tdm_conv_enable), .audio_clk_from_tdm(audio_clk_from_tdm),
    .rx_audio_to_pins(rx_audio_to_pins), .local_audio_select(local_audio_select),
    .audio_fifo_flush(audio_fifo_flush));
`default_nettype wire
